// ===== pqc_map.svh
// register map, field positions, reset values of the priority classifier
// assumes byte-wide registers on a plain address/strobe port
`ifndef PQC_MAP_SVH
`define PQC_MAP_SVH

`define PQC_ADDR_W          8
`define PQC_DATA_W          8

`define PQC_OFS_LOWER_MAP   8'h80
`define PQC_OFS_UPPER_MAP   8'h81
`define PQC_OFS_SPLIT       8'h82
`define PQC_OFS_MODE        8'hF0
`define PQC_OFS_LAST        8'hF1
`define PQC_OFS_CNT_LOW     8'hF2
`define PQC_OFS_CNT_HIGH    8'hF3

`define PQC_RST_LOWER_MAP   8'h50
`define PQC_RST_UPPER_MAP   8'hFA
`define PQC_RST_THRESHOLD   2'h2
`define PQC_RST_MODE        1'h0

`define PQC_THR_MSB         7
`define PQC_THR_LSB         6
`define PQC_SPLIT_FIXED     6'h04
`define PQC_MODE_TWO_Q_BIT  0

`define PQC_CNT_MAX         8'hFF
`define PQC_READ_ZERO       8'h00

`endif

// ===== pqc_pkg.sv
// types shared by the priority classifier
// assumes pqc_map.svh is on the include path
package pqc_pkg;

  typedef enum logic [1:0] {
    PQC_THR_ONLY_3    = 2'h0,
    PQC_THR_BAD       = 2'h1,
    PQC_THR_2_AND_UP  = 2'h2,
    PQC_THR_1_AND_UP  = 2'h3
  } pqc_thr_e;

  typedef struct packed {
    logic       valid;
    logic [2:0] tag;
    logic       use_ds;
    logic [1:0] ds_prio;
  } pqc_req_s;

  typedef struct packed {
    logic       valid;
    logic [1:0] prio;
    logic       high;
  } pqc_res_s;

endpackage : pqc_pkg

// ===== pqc_classifier.sv
// priority classifier: tag to 2-bit priority, then low/high queue split
// assumes requests come from parser logic on clk_sys_i, one per cycle
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`include "pqc_map.svh"

module pqc_classifier
  import pqc_pkg::*;
(
  input  wire logic                   clk_sys_i,
  input  wire logic                   rst_n_i,
  input  wire logic [`PQC_ADDR_W-1:0] reg_addr_i,
  input  wire logic [`PQC_DATA_W-1:0] reg_wdata_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  output logic      [`PQC_DATA_W-1:0] reg_rdata_o,
  input  wire pqc_req_s               req_i,
  output pqc_res_s                    res_o,
  output logic                        two_queue_o
);

  // priority field of a map byte, two bits per tag
  function automatic logic [1:0] map_field(
    input logic [7:0] map_byte,
    input logic [1:0] idx
  );
    logic [1:0] f;
    f = 2'h0;
    unique case (idx)
      2'h0: f = map_byte[1:0];
      2'h1: f = map_byte[3:2];
      2'h2: f = map_byte[5:4];
      2'h3: f = map_byte[7:6];
    endcase
    return f;
  endfunction

  // unsupported code 01 behaves like the reset split, a safe fallback
  function automatic logic goes_high(
    input logic [1:0] prio,
    input pqc_thr_e   thr
  );
    logic h;
    h = 1'b0;
    unique case (thr)
      PQC_THR_ONLY_3:   h = (prio == 2'h3);
      PQC_THR_BAD:      h = (prio >= 2'h2);
      PQC_THR_2_AND_UP: h = (prio >= 2'h2);
      PQC_THR_1_AND_UP: h = (prio >= 2'h1);
    endcase
    return h;
  endfunction

  // saturating event counter, clear wins over a count
  function automatic logic [7:0] cnt_step(
    input logic [7:0] cnt,
    input logic       clr,
    input logic       inc
  );
    logic [7:0] n;
    n = cnt;
    if (clr) begin
      n = 8'h00;
    end else if (inc && (cnt != `PQC_CNT_MAX)) begin
      n = cnt + 8'h01;
    end
    return n;
  endfunction

  // configuration state
  logic [7:0] lower_map;
  logic [7:0] upper_map;
  pqc_thr_e   two_queue_threshold;
  logic       two_q_en;
  logic [7:0] next_lower_map;
  logic [7:0] next_upper_map;
  pqc_thr_e   next_two_queue_threshold;
  logic       next_two_q_en;

  // observation state
  logic [7:0] cnt_low;
  logic [7:0] cnt_high;
  logic [3:0] last_res;
  logic [7:0] next_cnt_low;
  logic [7:0] next_cnt_high;
  logic [3:0] next_last_res;

  // output state
  pqc_res_s   res_q;
  logic       two_q_q;
  logic [7:0] rdata_q;
  pqc_res_s   next_res;
  logic       next_two_q;
  logic [7:0] next_rdata;

  // classification datapath
  logic [1:0] tag_prio;
  logic [1:0] sel_prio;
  logic       sel_high;

  always_comb begin
    tag_prio = 2'h0;
    if (req_i.tag[2]) begin
      tag_prio = map_field(upper_map, req_i.tag[1:0]);
    end else begin
      tag_prio = map_field(lower_map, req_i.tag[1:0]);
    end
    sel_prio = req_i.use_ds ? req_i.ds_prio : tag_prio;
    sel_high = two_q_en && goes_high(sel_prio, two_queue_threshold);
  end

  // register writes; a write takes effect from the next cycle
  always_comb begin
    next_lower_map           = lower_map;
    next_upper_map           = upper_map;
    next_two_queue_threshold = two_queue_threshold;
    next_two_q_en            = two_q_en;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        `PQC_OFS_LOWER_MAP: begin
          next_lower_map = reg_wdata_i;
        end
        `PQC_OFS_UPPER_MAP: begin
          next_upper_map = reg_wdata_i;
        end
        `PQC_OFS_SPLIT: begin
          next_two_queue_threshold =
            pqc_thr_e'(reg_wdata_i[`PQC_THR_MSB:`PQC_THR_LSB]);
        end
        `PQC_OFS_MODE: begin
          next_two_q_en = reg_wdata_i[`PQC_MODE_TWO_Q_BIT];
        end
        default: begin
          next_two_q_en = two_q_en;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lower_map           <= `PQC_RST_LOWER_MAP;
      upper_map           <= `PQC_RST_UPPER_MAP;
      two_queue_threshold <= pqc_thr_e'(`PQC_RST_THRESHOLD);
      two_q_en            <= `PQC_RST_MODE;
    end else begin
      lower_map           <= next_lower_map;
      upper_map           <= next_upper_map;
      two_queue_threshold <= next_two_queue_threshold;
      two_q_en            <= next_two_q_en;
    end
  end

  // counters count queue decisions; a write clears
  logic clr_low;
  logic clr_high;

  always_comb begin
    clr_low  = reg_wr_i && (reg_addr_i == `PQC_OFS_CNT_LOW);
    clr_high = reg_wr_i && (reg_addr_i == `PQC_OFS_CNT_HIGH);
    next_cnt_low  = cnt_step(cnt_low, clr_low,
                             req_i.valid && two_q_en && !sel_high);
    next_cnt_high = cnt_step(cnt_high, clr_high,
                             req_i.valid && sel_high);
    next_last_res = last_res;
    if (req_i.valid) begin
      next_last_res = {1'b1, sel_prio, sel_high};
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_low  <= 8'h00;
      cnt_high <= 8'h00;
      last_res <= 4'h0;
    end else begin
      cnt_low  <= next_cnt_low;
      cnt_high <= next_cnt_high;
      last_res <= next_last_res;
    end
  end

  // read mux and result register, one cycle after the request
  always_comb begin
    next_rdata = rdata_q;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `PQC_OFS_LOWER_MAP: begin
          next_rdata = lower_map;
        end
        `PQC_OFS_UPPER_MAP: begin
          next_rdata = upper_map;
        end
        `PQC_OFS_SPLIT: begin
          next_rdata = {two_queue_threshold, `PQC_SPLIT_FIXED};
        end
        `PQC_OFS_MODE: begin
          next_rdata = {7'h00, two_q_en};
        end
        `PQC_OFS_LAST: begin
          next_rdata = {4'h0, last_res};
        end
        `PQC_OFS_CNT_LOW: begin
          next_rdata = cnt_low;
        end
        `PQC_OFS_CNT_HIGH: begin
          next_rdata = cnt_high;
        end
        default: begin
          next_rdata = `PQC_READ_ZERO;
        end
      endcase
    end else begin
      // data stand only in the cycle after the strobe
      next_rdata = `PQC_READ_ZERO;
    end
    next_res.valid = req_i.valid;
    next_res.prio  = req_i.valid ? sel_prio : 2'h0;
    next_res.high  = req_i.valid && sel_high;
    next_two_q     = two_q_en;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= 8'h00;
      res_q   <= '0;
      two_q_q <= 1'b0;
    end else begin
      rdata_q <= next_rdata;
      res_q   <= next_res;
      two_q_q <= next_two_q;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign res_o       = res_q;
  assign two_queue_o = two_q_q;

endmodule // pqc_classifier

// ===== pqc_classifier_sva.sv
// port checker for the priority classifier
// assumes a bind into pqc_classifier, one clock domain
`timescale 1ns/1ps
module pqc_classifier_sva
  import pqc_pkg::*;
(
  input wire logic       clk_sys_i,
  input wire logic       rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire pqc_req_s   req_i,
  input wire pqc_res_s   res_o,
  input wire logic       two_queue_o
);
  logic [7:0] umap;
  logic [7:0] lmap;
  logic [1:0] thr;
  logic [1:0] up_exp;
  logic [1:0] lo_exp;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // shadows follow software writes only
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      umap <= 8'hFA;
      lmap <= 8'h50;
      thr  <= 2'h2;
    end else if (reg_wr_i && reg_addr_i == 8'h81) begin
      umap <= reg_wdata_i;
    end else if (reg_wr_i && reg_addr_i == 8'h80) begin
      lmap <= reg_wdata_i;
    end else if (reg_wr_i && reg_addr_i == 8'h82) begin
      thr  <= reg_wdata_i[7:6];
    end
  end
  assign up_exp = umap[{req_i.tag[1:0], 1'b0} +: 2];
  assign lo_exp = lmap[{req_i.tag[1:0], 1'b0} +: 2];
  sequence s_q2;
    res_o.valid && two_queue_o && $past(two_queue_o);
  endsequence
  property p_ds;
    req_i.valid && req_i.use_ds |=> res_o.prio == $past(req_i.ds_prio);
  endproperty
  property p_up;
    req_i.valid && !req_i.use_ds && req_i.tag[2] |=>
      res_o.prio == $past(up_exp);
  endproperty
  property p_low;
    req_i.valid && !req_i.use_ds && !req_i.tag[2] |=>
      res_o.prio == $past(lo_exp);
  endproperty
  // mode copy lags the enable by one cycle, as the result does
  property p_off;
    res_o.valid && !two_queue_o |-> !res_o.high;
  endproperty
  property p_t0;
    s_q2 ##0 $past(thr) == 2'h0 |-> res_o.high == (res_o.prio == 2'h3);
  endproperty
  property p_t2;
    s_q2 ##0 $past(thr) == 2'h2 |-> res_o.high == res_o.prio[1];
  endproperty
  property p_t3;
    s_q2 ##0 $past(thr) == 2'h3 |-> res_o.high == (res_o.prio != 2'h0);
  endproperty
  property p_rsv;
    reg_rd_i && reg_addr_i == 8'h82 |=> reg_rdata_o == {$past(thr), 6'h04};
  endproperty
  property p_map;
    reg_rd_i && reg_addr_i == 8'h81 |=> reg_rdata_o == $past(umap);
  endproperty
  a_ds: assert property (p_ds)
    else $error("ds priority not passed");
  a_up: assert property (p_up)
    else $error("upper tag map wrong");
  a_low: assert property (p_low)
    else $error("lower tag map wrong");
  a_off: assert property (p_off)
    else $error("high queue while split off");
  a_t0: assert property (p_t0)
    else $error("threshold 00 split wrong");
  a_t2: assert property (p_t2)
    else $error("threshold 10 split wrong");
  a_t3: assert property (p_t3)
    else $error("threshold 11 split wrong");
  a_rsv: assert property (p_rsv)
    else $error("split register readback wrong");
  a_map: assert property (p_map)
    else $error("upper map readback wrong");
endmodule // pqc_classifier_sva

bind pqc_classifier pqc_classifier_sva u_sva (.clk_sys_i(clk_sys_i),
  .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .req_i(req_i), .res_o(res_o), .two_queue_o(two_queue_o));

// ===== pqc_parser_model.sv
// far-side model: frame parser issuing classify requests
// assumes the bench calls send, one-cycle request pulses
`timescale 1ns/1ps
module pqc_parser_model
  import pqc_pkg::*;
(
  input  wire logic clk_sys_i,
  output pqc_req_s  req_o
);
  initial req_o = '0;
  // idle fields inverted so a stale tag never matches
  task automatic send(input logic [2:0] t, input logic d,
                      input logic [1:0] p);
    @(posedge clk_sys_i);
    req_o <= {1'b1, t, d, p};
    @(posedge clk_sys_i);
    req_o <= {1'b0, ~t, ~d, ~p};
  endtask
endmodule // pqc_parser_model

// ===== pqc_classifier_test.sv
// self-checking bench for pqc_classifier
// assumes a 125 MHz clock and the parser model on the request port
`timescale 1ns/1ps
module pqc_classifier_test;
  import pqc_pkg::*;
  logic       clk_sys_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o;
  pqc_req_s   req_i;
  pqc_res_s   res_o;
  logic       two_queue_o;
  int         fail_count = 0, n_tests = 0, cycles = 0;
  pqc_classifier uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .req_i(req_i), .res_o(res_o), .two_queue_o(two_queue_o));
  pqc_parser_model u_far (.clk_sys_i(clk_sys_i), .req_o(req_i));
  initial forever #4 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      results();
    end
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i   <= 1'b0;
    #1 cmp(reg_rdata_o, exp);
  endtask
  task automatic cls(input logic [2:0] t, input logic d,
                     input logic [1:0] p, input logic [3:0] exp);
    u_far.send(t, d, p);
    #1 cmp({4'h0, res_o}, {4'h0, exp});
  endtask
  task automatic t_reset_vals();
    rd(8'h81, 8'hFA);
    rd(8'h80, 8'h50);
    rd(8'h82, 8'h84);
    rd(8'h10, 8'h00);
    rd(8'hF0, 8'h00);
    rd(8'hF1, 8'h00);
    rd(8'hF2, 8'h00);
    rd(8'hF3, 8'h00);
    cmp({7'h00, two_queue_o}, 8'h00);
  endtask
  task automatic t_default_map();
    for (int t = 0; t < 8; t++)
      cls(3'(t), 1'b0, 2'h0, {1'b1, 2'(t >> 1), 1'b0});
  endtask
  task automatic t_split();
    logic [1:0] thr;
    wr(8'hF0, 8'hFF);
    for (int i = 0; i < 3; i++) begin
      thr = (i == 0) ? 2'h0 : 2'h1 + 2'(i);
      wr(8'h82, {thr, 6'h3B});
      rd(8'h82, {thr, 6'h04});
      for (int p = 0; p < 4; p++)
        cls(3'h7, 1'b1, 2'(p), {1'b1, 2'(p), p > 2 - i});
    end
  endtask
  task automatic t_remap();
    wr(8'h81, 8'h1B);
    wr(8'h80, 8'hE4);
    for (int t = 0; t < 8; t++)
      cls(3'(t), 1'b0, 2'h3,
          {1'b1, 2'(t < 4 ? t : 7 - t), t != 0 && t != 7});
  endtask
  // mode bits 7-1 read zero; counters cleared then counted once each
  task automatic t_own_regs();
    rd(8'hF0, 8'h01);
    cmp({7'h00, two_queue_o}, 8'h01);
    wr(8'hF2, 8'h00);
    wr(8'hF3, 8'h00);
    cls(3'h7, 1'b0, 2'h0, 4'h8);
    cls(3'h4, 1'b0, 2'h0, 4'hF);
    rd(8'hF1, 8'h0F);
    rd(8'hF2, 8'h01);
    rd(8'hF3, 8'h01);
    @(posedge clk_sys_i);
    #1 cmp(reg_rdata_o, 8'h00);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_reset_vals();
    t_default_map();
    t_split();
    t_remap();
    t_own_regs();
    @(posedge clk_sys_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_reset_vals();
    results();
  end
endmodule // pqc_classifier_test
